//--- logic/esf_follower.sv
// Purpose: slave synchronisation input, count to position and speed offsets
// Assumes: APB3 slave, zero wait states, pins asynchronous to pclk
// Notes:   angle sampled every SAMPLE_CYC cycles, gear divider runs per sample
// Behaviour
// - 16-bit counter; zero pulse loads 0 counting up, increments-1 counting down
// - Quadrature pins pass a digital noise filter set for 500 kHz cutoff
// - Count is normalised to a 16-bit angle for any line count
// - Slave offset is added to the angle and direction reversal applied
// - Line count is one of 32, 64, 128, 256, 512 or 1024
// - Gear numerator and denominator set separately, ratio 1:1000 to 1000:1
// - Quadrature input works with the zero pulse used or ignored
// - Step pulse plus direction input is accepted instead
// - Software can reverse the counting direction
// - Angle difference times gear ratio is integrated into position offset
// - Speed offset from same difference, smoothed by first-order low-pass
// - Speed-synchronous mode feeds only the speed offset to speed control
// - Angle-synchronous mode enables position control, speed offset as feed-forward
// - Torque control with synchronisation is rejected, sync selection ignored
// - Speed plus sync needs setpoint source set to the speed offset
// - Positioning plus sync lets a profile ride on the sync motion
// - New line count takes effect only after a controller restart
`timescale 1ns/1ns
`include "esf_defines.svh"
module esf_follower
  import esf_pkg::*;
#(
  parameter int unsigned AW         = 8,
  parameter int unsigned SAMPLE_CYC = `ESF_SAMPLE_CYC,
  parameter int unsigned FILT_CYC   = `ESF_FILT_CYC
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          sync_connector_a,
  input  wire logic          sync_connector_b,
  input  wire logic          sync_connector_z,
  input  wire logic [31:0]   profile_pos,
  output logic      [15:0]   speed_offset,
  output logic      [15:0]   pos_feedfwd,
  output logic      [31:0]   pos_setpoint,
  output logic               pos_ctrl_en,
  output logic               sync_active
);
  esf_core_s_t        s;
  esf_core_s_t        next_s;
  logic [3:0]         shift;
  logic [15:0]        norm;
  logic [15:0]        zmax_m1;
  logic               a_now;
  logic               b_now;
  logic               z_now;
  logic               step;
  logic               up;
  logic               zero_hit;
  logic               wr;
  logic               hit;
  logic [31:0]        rd;
  logic [15:0]        nsync;
  logic signed [39:0] qx;
  logic               op_ok;
  logic               mode_ok;

  esf_link_if lk ();

  // Noise filter ahead of the decoder
  esf_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    ({sync_connector_z, sync_connector_b, sync_connector_a}),
    .lk      (lk)
  );

  esf_gear u_gear (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk)
  );

  assign lk.start  = s.start;
  assign lk.delta  = s.delta;
  assign lk.num    = s.num;
  assign lk.den    = s.den;
  assign lk.rem_in = s.rem;

  always_comb begin
    next_s   = s;
    next_s.start = 1'b0;
    a_now    = lk.lvl[0];
    b_now    = lk.lvl[1];
    z_now    = lk.lvl[2];
    step     = 1'b0;
    up       = 1'b0;
    zero_hit = 1'b0;
    wr       = psel && penable && pwrite;
    hit      = 1'b1;
    rd       = '0;
    qx       = 40'(lk.q);
    nsync    = s.nacc[`ESF_FRAC+15:`ESF_FRAC];
    op_ok    = 1'b1;
    mode_ok  = 1'b1;

    // Quadrature counts four per line, step input one per line
    if (s.in_mode == ESF_IN_STEP) begin
      shift = `ESF_STEP_SHIFT - {1'b0, s.line_act};
    end else begin
      shift = `ESF_QUAD_SHIFT - {1'b0, s.line_act};
    end
    zmax_m1 = (16'h0001 << (5'h10 - {1'b0, shift})) - 16'h0001;

    // Decoder
    if (s.in_mode == ESF_IN_STEP) begin
      step = a_now && !s.a_d;
      up   = b_now;
    end else begin
      step = (a_now ^ s.a_d) ^ (b_now ^ s.b_d);
      up   = a_now ^ s.b_d;
      zero_hit = (s.in_mode == ESF_IN_QUAD_Z) && z_now && !s.z_d;
    end
    next_s.a_d = a_now;
    next_s.b_d = b_now;
    next_s.z_d = z_now;
    if (step) begin
      next_s.dir_up = up;
    end
    if (zero_hit) begin
      next_s.cnt = s.dir_up ? 16'h0000 : zmax_m1;
    end else if (step) begin
      next_s.cnt = up ? s.cnt + 16'h0001 : s.cnt - 16'h0001;
    end

    // Normalise, reverse and offset the angle
    norm = s.cnt << shift;
    next_s.angle = (s.dir_rev ? 16'h0000 - norm : norm) + s.offset;

    // Sample divider and differentiation
    if (s.div_cnt == 10'(SAMPLE_CYC - 1)) begin
      next_s.div_cnt  = '0;
      next_s.ang_prev = s.angle;
      if (s.prime) begin
        next_s.prime = 1'b0;
      end else begin
        next_s.delta = $signed(s.angle - s.ang_prev);
        next_s.start = 1'b1;
      end
    end else begin
      next_s.div_cnt = s.div_cnt + 10'h001;
    end

    // Geared difference into position and filtered speed
    if (lk.done) begin
      next_s.rem   = lk.rem_out;
      next_s.xsync = s.xsync + 32'(lk.q);
      next_s.nacc  = s.nacc + (((qx <<< `ESF_FRAC) - s.nacc) >>> s.pt1_sh);
    end

    // Mode combinations
    next_s.sync_act = s.sync_sel && ((s.op == ESF_OP_SPEED && s.sp_sync) ||
                                     s.op == ESF_OP_POS);
    next_s.sp_err   = s.sync_sel && s.op == ESF_OP_SPEED && !s.sp_sync;
    next_s.spd_off  = (s.sync_act && s.op == ESF_OP_SPEED) ? nsync : 16'h0000;
    next_s.pos_en   = (s.op == ESF_OP_POS);
    next_s.ff_spd   = (s.sync_act && s.op == ESF_OP_POS) ? nsync : 16'h0000;
    next_s.pos_set  = profile_pos +
                      ((s.sync_act && s.op == ESF_OP_POS) ? s.xsync : 32'h0);

    // Register decode
    if (paddr == `ESF_REG_CTRL) begin
      rd[1:0]                                    = s.op;
      rd[`ESF_CTRL_SYNC]                         = s.sync_sel;
      rd[`ESF_CTRL_SPSRC]                        = s.sp_sync;
      rd[`ESF_CTRL_MODE_LO+1:`ESF_CTRL_MODE_LO]  = s.in_mode;
      rd[`ESF_CTRL_REV]                          = s.dir_rev;
    end else if (paddr == `ESF_REG_LINES) begin
      rd[2:0]                                    = s.line_pend;
      rd[`ESF_LINES_ACT_LO+2:`ESF_LINES_ACT_LO]  = s.line_act;
    end else if (paddr == `ESF_REG_OFFSET) begin
      rd[15:0] = s.offset;
    end else if (paddr == `ESF_REG_NUM) begin
      rd[9:0] = s.num;
    end else if (paddr == `ESF_REG_DEN) begin
      rd[9:0] = s.den;
    end else if (paddr == `ESF_REG_PT1) begin
      rd[3:0] = s.pt1_sh;
    end else if (paddr == `ESF_REG_STATUS) begin
      rd[15:0]           = s.cnt;
      rd[`ESF_ST_ACT]    = s.sync_act;
      rd[`ESF_ST_REJ]    = s.rej;
      rd[`ESF_ST_SPERR]  = s.sp_err;
    end else if (paddr == `ESF_REG_ANGLE) begin
      rd[15:0] = s.angle;
    end else if (paddr == `ESF_REG_XSYNC) begin
      rd = s.xsync;
    end else if (paddr == `ESF_REG_NSYNC) begin
      rd[15:0] = nsync;
    end else begin
      hit = 1'b0;
    end

    // Read data and error are caught in the setup cycle
    if (psel && !penable) begin
      next_s.prdata  = rd;
      next_s.pslverr = !hit;
    end

    // Register writes
    if (wr && hit) begin
      if (paddr == `ESF_REG_CTRL) begin
        op_ok   = pwdata[1:0] != 2'h3;
        mode_ok = pwdata[`ESF_CTRL_MODE_LO+1:`ESF_CTRL_MODE_LO] != 2'h3;
        if (op_ok) begin
          next_s.op = esf_op_t'(pwdata[1:0]);
          // Sync request alongside torque control is dropped
          next_s.rej      = (pwdata[1:0] == ESF_OP_TORQUE) && pwdata[`ESF_CTRL_SYNC];
          next_s.sync_sel = (pwdata[1:0] != ESF_OP_TORQUE) && pwdata[`ESF_CTRL_SYNC];
        end
        next_s.sp_sync = pwdata[`ESF_CTRL_SPSRC];
        if (mode_ok) begin
          next_s.in_mode = esf_in_t'(pwdata[`ESF_CTRL_MODE_LO+1:`ESF_CTRL_MODE_LO]);
        end
        next_s.dir_rev = pwdata[`ESF_CTRL_REV];
        if (pwdata[`ESF_CTRL_RESTART]) begin
          // Controller restart: pending line count becomes active
          next_s.line_act = s.line_pend;
          next_s.cnt      = '0;
          next_s.xsync    = '0;
          next_s.nacc     = '0;
          next_s.rem      = '0;
          next_s.prime    = 1'b1;
          next_s.div_cnt  = '0;
          next_s.start    = 1'b0;
        end
      end else if (paddr == `ESF_REG_LINES) begin
        if (pwdata[2:0] <= `ESF_LINE_MAX) begin
          next_s.line_pend = pwdata[2:0];
        end
      end else if (paddr == `ESF_REG_OFFSET) begin
        next_s.offset = pwdata[15:0];
      end else if (paddr == `ESF_REG_NUM) begin
        if (pwdata[31:10] == '0 && pwdata[9:0] != '0 && pwdata[9:0] <= `ESF_GEAR_MAX) begin
          next_s.num = pwdata[9:0];
        end
      end else if (paddr == `ESF_REG_DEN) begin
        if (pwdata[31:10] == '0 && pwdata[9:0] != '0 && pwdata[9:0] <= `ESF_GEAR_MAX) begin
          next_s.den = pwdata[9:0];
        end
      end else if (paddr == `ESF_REG_PT1) begin
        next_s.pt1_sh = pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.line_pend <= `ESF_LINE_RST;
      s.line_act  <= `ESF_LINE_RST;
      s.num       <= 10'h001;
      s.den       <= 10'h001;
      s.pt1_sh    <= `ESF_PT1_RST;
      s.prime     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pready       = 1'b1;
  assign prdata       = s.prdata;
  assign pslverr      = s.pslverr;
  assign speed_offset = s.spd_off;
  assign pos_feedfwd  = s.ff_spd;
  assign pos_setpoint = s.pos_set;
  assign pos_ctrl_en  = s.pos_en;
  assign sync_active  = s.sync_act;
endmodule

//--- logic/esf_defines.svh
// Purpose: constants of the encoder sync follower
// Assumes: included by its bare name
// Notes:   offsets are APB byte addresses
`ifndef ESF_DEFINES_SVH
`define ESF_DEFINES_SVH
`define ESF_CLK_KHZ      20000
`define ESF_FILT_KHZ     500
`define ESF_FILT_CYC     (`ESF_CLK_KHZ / (2 * `ESF_FILT_KHZ))
`define ESF_FILT_CW      5
`define ESF_SAMPLE_US    50
`define ESF_SAMPLE_CYC   (`ESF_SAMPLE_US * `ESF_CLK_KHZ / 1000)
`define ESF_GEAR_MAX     10'h3E8
`define ESF_LINE_MAX     3'h5
`define ESF_LINE_RST     3'h5
`define ESF_PT1_RST      4'h4
`define ESF_QUAD_SHIFT   4'h9
`define ESF_STEP_SHIFT   4'hB
`define ESF_FRAC         8
`define ESF_REG_CTRL     8'h00
`define ESF_REG_LINES    8'h04
`define ESF_REG_OFFSET   8'h08
`define ESF_REG_NUM      8'h0C
`define ESF_REG_DEN      8'h10
`define ESF_REG_PT1      8'h14
`define ESF_REG_STATUS   8'h18
`define ESF_REG_ANGLE    8'h1C
`define ESF_REG_XSYNC    8'h20
`define ESF_REG_NSYNC    8'h24
`define ESF_CTRL_SYNC    2
`define ESF_CTRL_SPSRC   3
`define ESF_CTRL_MODE_LO 4
`define ESF_CTRL_REV     6
`define ESF_CTRL_RESTART 7
`define ESF_LINES_ACT_LO 8
`define ESF_ST_ACT       16
`define ESF_ST_REJ       17
`define ESF_ST_SPERR     18
`endif

//--- logic/esf_pkg.sv
// Purpose: types of the encoder sync follower
// Assumes: esf_defines.svh holds the numbers
// Notes:   one packed state struct per module
package esf_pkg;
`include "esf_defines.svh"
  typedef enum logic [1:0] {ESF_OP_TORQUE = 2'h0, ESF_OP_SPEED = 2'h1,
                            ESF_OP_POS = 2'h2} esf_op_t;
  typedef enum logic [1:0] {ESF_IN_QUAD_Z = 2'h0, ESF_IN_QUAD = 2'h1,
                            ESF_IN_STEP = 2'h2} esf_in_t;
  typedef enum logic {ESF_G_IDLE = 1'h0, ESF_G_RUN = 1'h1} esf_gst_t;
  typedef struct packed {
    logic [2:0]                  s1;
    logic [2:0]                  s2;
    logic [2:0]                  lvl;
    logic [2:0][`ESF_FILT_CW-1:0] cnt;
  } esf_filt_s_t;
  typedef struct packed {
    esf_gst_t           st;
    logic [9:0]         den;
    logic [4:0]         cnt;
    logic [25:0]        dvd;
    logic [25:0]        quo;
    logic [10:0]        pr;
    logic               neg;
    logic               done;
    logic signed [26:0] q;
    logic signed [10:0] r;
  } esf_gear_s_t;
  typedef struct packed {
    esf_op_t            op;
    logic               sync_sel;
    logic               sp_sync;
    esf_in_t            in_mode;
    logic               dir_rev;
    logic [2:0]         line_pend;
    logic [2:0]         line_act;
    logic [15:0]        offset;
    logic [9:0]         num;
    logic [9:0]         den;
    logic [3:0]         pt1_sh;
    logic [15:0]        cnt;
    logic               a_d;
    logic               b_d;
    logic               z_d;
    logic               dir_up;
    logic [9:0]         div_cnt;
    logic               prime;
    logic [15:0]        angle;
    logic [15:0]        ang_prev;
    logic signed [15:0] delta;
    logic               start;
    logic signed [10:0] rem;
    logic signed [31:0] xsync;
    logic signed [39:0] nacc;
    logic               rej;
    logic               sp_err;
    logic               sync_act;
    logic [15:0]        spd_off;
    logic [15:0]        ff_spd;
    logic [31:0]        pos_set;
    logic               pos_en;
    logic [31:0]        prdata;
    logic               pslverr;
  } esf_core_s_t;
endpackage

//--- logic/esf_link_if.sv
// Purpose: filtered levels and gear divider hand-off
// Assumes: all parties on pclk
// Notes:   start and done are one-cycle pulses
`timescale 1ns/1ns
interface esf_link_if;
  logic [2:0]         lvl;
  logic               start;
  logic signed [15:0] delta;
  logic [9:0]         num;
  logic [9:0]         den;
  logic signed [10:0] rem_in;
  logic               done;
  logic signed [26:0] q;
  logic signed [10:0] rem_out;
  modport filt (output lvl);
  modport gear (input start, delta, num, den, rem_in, output done, q, rem_out);
  modport core (input lvl, done, q, rem_out, output start, delta, num, den, rem_in);
endinterface

//--- logic/esf_filter.sv
// Purpose: pin synchroniser and digital noise filter
// Assumes: pins are asynchronous to pclk
// Notes:   a level passes once stable for FILT_CYC cycles
`timescale 1ns/1ns
`include "esf_defines.svh"
module esf_filter
  import esf_pkg::*;
#(
  parameter int unsigned FILT_CYC = `ESF_FILT_CYC
)(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] pins,
  esf_link_if.filt        lk
);
  esf_filt_s_t s;
  esf_filt_s_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    for (int i = 0; i < 3; i++) begin
      if (s.s2[i] == s.lvl[i]) begin
        next_s.cnt[i] = '0;
      end else if (s.cnt[i] == `ESF_FILT_CW'(FILT_CYC - 1)) begin
        next_s.lvl[i] = s.s2[i];
        next_s.cnt[i] = '0;
      end else begin
        next_s.cnt[i] = s.cnt[i] + `ESF_FILT_CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lk.lvl = s.lvl;
endmodule

//--- logic/esf_gear.sv
// Purpose: gear scaling q = (delta * num + rem) / den
// Assumes: den is 1..1000, start only while idle
// Notes:   remainder is fed back so no drift builds up
`timescale 1ns/1ns
module esf_gear
  import esf_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  esf_link_if.gear  lk
);
  esf_gear_s_t        s;
  esf_gear_s_t        next_s;
  logic signed [26:0] prod;
  logic [10:0]        trial;
  logic [25:0]        quo_n;
  logic [10:0]        pr_n;
  logic               bit_q;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    prod  = 27'(lk.delta) * 27'($signed({1'b0, lk.num})) + 27'(lk.rem_in);
    trial = {s.pr[9:0], s.dvd[25]};
    bit_q = (trial >= {1'b0, s.den});
    pr_n  = bit_q ? trial - {1'b0, s.den} : trial;
    quo_n = {s.quo[24:0], bit_q};
    case (s.st)
      ESF_G_IDLE: begin
        if (lk.start) begin
          next_s.neg = prod[26];
          next_s.dvd = prod[26] ? 26'(-prod) : prod[25:0];
          next_s.den = lk.den;
          next_s.quo = '0;
          next_s.pr  = '0;
          next_s.cnt = 5'h1A;
          next_s.st  = ESF_G_RUN;
        end
      end
      ESF_G_RUN: begin
        next_s.dvd = {s.dvd[24:0], 1'b0};
        next_s.pr  = pr_n;
        next_s.quo = quo_n;
        next_s.cnt = s.cnt - 5'h1;
        if (s.cnt == 5'h1) begin
          next_s.q    = s.neg ? -$signed({1'b0, quo_n}) : $signed({1'b0, quo_n});
          next_s.r    = s.neg ? -$signed(pr_n) : $signed(pr_n);
          next_s.done = 1'b1;
          next_s.st   = ESF_G_IDLE;
        end
      end
      default: next_s.st = ESF_G_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s     <= '0;
      s.den <= 10'h001;
    end else begin
      s <= next_s;
    end
  end

  assign lk.done    = s.done;
  assign lk.q       = s.q;
  assign lk.rem_out = s.r;
endmodule

//--- bench/esf_props.sv
// Purpose: port checker for esf_follower
// Assumes: bound to every esf_follower instance
// Notes:   APB answers and mode outputs only
`timescale 1ns/1ns
module esf_props #(
  parameter int unsigned AW         = 8,
  parameter int unsigned SAMPLE_CYC = 1000,
  parameter int unsigned FILT_CYC   = 20
)(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic [AW-1:0] paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          sync_connector_a,
  input wire logic          sync_connector_b,
  input wire logic          sync_connector_z,
  input wire logic [31:0]   profile_pos,
  input wire logic [15:0]   speed_offset,
  input wire logic [15:0]   pos_feedfwd,
  input wire logic [31:0]   pos_setpoint,
  input wire logic          pos_ctrl_en,
  input wire logic          sync_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
  sequence rd_unmapped;
    psel && !penable && !pwrite && paddr > 8'h24 ##1 psel && penable;
  endsequence
  sequence acc_mapped;
    psel && !penable && paddr <= 8'h24 && paddr[1:0] == 2'h0 ##1 psel && penable;
  endsequence
  sequence rd_ctrl;
    psel && !penable && !pwrite && paddr == 8'h00 ##1 psel && penable;
  endsequence
  unmapped_err_a: assert property (rd_unmapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (acc_mapped |-> !pslverr)
    else $error("mapped access refused");
  restart_rd0_a: assert property (rd_ctrl |-> !prdata[7])
    else $error("restart bit reads back set");
  mode_by_wr_a: assert property ($changed(pos_ctrl_en) || $changed(sync_active) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("mode changed without control write");
  spd_excl_a: assert property (speed_offset != 16'h0 |-> pos_feedfwd == 16'h0)
    else $error("speed offset and feed-forward both driven");
  ff_pos_a: assert property (pos_feedfwd != 16'h0 |-> pos_ctrl_en || $past(pos_ctrl_en))
    else $error("feed-forward without position control");
  spd_nopos_a: assert property (speed_offset != 16'h0 |->
    !pos_ctrl_en || !$past(pos_ctrl_en)) else $error("speed offset in position mode");
  setpt_pass_a: assert property ($past(presetn) && !sync_active && !$past(sync_active) |->
    pos_setpoint == $past(profile_pos)) else $error("setpoint not the profile");
  torque_nosync_a: assert property (ctrl_wr && pwdata[1:0] == 2'h0 |->
    ##2 !sync_active) else $error("sync engaged under torque control");
  pos_enable_a: assert property (ctrl_wr && pwdata[1:0] == 2'h2 |->
    ##2 pos_ctrl_en) else $error("position control not enabled");
endmodule
bind esf_follower esf_props #(.AW(AW), .SAMPLE_CYC(SAMPLE_CYC), .FILT_CYC(FILT_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sync_connector_a(sync_connector_a), .sync_connector_b(sync_connector_b),
  .sync_connector_z(sync_connector_z), .profile_pos(profile_pos),
  .speed_offset(speed_offset), .pos_feedfwd(pos_feedfwd), .pos_setpoint(pos_setpoint),
  .pos_ctrl_en(pos_ctrl_en), .sync_active(sync_active));

//--- bench/esf_enc_src.sv
// Purpose: master drive model on the sync connector
// Assumes: tasks called just after a pclk edge
// Notes:   gap is the edge spacing in cycles
`timescale 1ns/1ns
module esf_enc_src (
  input  wire logic pclk,
  output logic      a,
  output logic      b,
  output logic      z
);
  logic [1:0] ph;
  initial begin
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
    ph = 2'h0;
  end
  // Gray phase, A leading B counts up
  task automatic quad(input int n, input logic up, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge pclk);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      a <= ph[0] ^ ph[1];
      b <= ph[1];
    end
  endtask
  task automatic step(input int n, input logic up, input int gap);
    a <= 1'b0;
    b <= up;
    repeat (n) begin
      repeat (gap) @(posedge pclk);
      a <= 1'b1;
      repeat (gap) @(posedge pclk);
      a <= 1'b0;
    end
    repeat (gap) @(posedge pclk);
  endtask
  task automatic zero(input int gap);
    z <= 1'b1;
    repeat (gap) @(posedge pclk);
    z <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
  // One-cycle spike, shorter than the filter accepts
  task automatic glitch();
    a <= ~a;
    @(posedge pclk);
    a <= ~a;
    repeat (8) @(posedge pclk);
  endtask
endmodule

//--- bench/tb_top.sv
// Purpose: self-checking bench for esf_follower
// Assumes: short sample and filter counts
// Notes:   reads queue their expected value for the monitor
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned SCYC = 40;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        a, b, z, pos_ctrl_en, sync_active;
  logic [7:0]  paddr;
  logic [15:0] speed_offset, pos_feedfwd;
  logic [31:0] pwdata, prdata, profile_pos, pos_setpoint, rnd;
  logic [63:0] expq[$];
  logic [19:0] tbl[6] = '{20'h24204, 20'h25258, 20'h2D2D2, 20'h26263, 20'h22221, 20'h23221};
  int          error_cnt, checks_done, n;
  esf_follower #(.SAMPLE_CYC(SCYC), .FILT_CYC(3)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_connector_a(a), .sync_connector_b(b), .sync_connector_z(z),
    .profile_pos(profile_pos), .speed_offset(speed_offset), .pos_feedfwd(pos_feedfwd),
    .pos_setpoint(pos_setpoint), .pos_ctrl_en(pos_ctrl_en), .sync_active(sync_active));
  esf_enc_src SRC (.pclk(pclk), .a(a), .b(b), .z(z));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    expq.push_back({m, e & m});
    apb(1'b0, ad, 32'h0);
  endtask
  // Compares each completed read against the oldest queued note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) begin
      chk(prdata & expq[0][63:32], expq[0][31:0]);
      void'(expq.pop_front());
    end
  end
  initial begin
    cyc(40000);
    error_cnt++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, profile_pos} = '0;
    error_cnt = 0;
    checks_done = 0;
    rnd = 32'h3D786A36;
    presetn = 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rd(8'h00, 32'h0, 32'hFFFFFFFF);
    rd(8'h04, 32'h505, 32'h707);
    rd(8'h14, 32'h4, 32'hF);
    rd(8'h28, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'd1001);
    rd(8'h0C, 32'h1, 32'h3FF);
    rd(8'h10, 32'h1, 32'h3FF);
    apb(1'b1, 8'h04, 32'h6);
    rd(8'h04, 32'h505, 32'h707);
    apb(1'b1, 8'h04, 32'h0);
    rd(8'h04, 32'h500, 32'h707);
    apb(1'b1, 8'h00, 32'h90);
    rd(8'h04, 32'h000, 32'h707);
    rnd = lfsr(rnd);
    n = int'(rnd[4:0] | 5'h1);
    SRC.quad(n, 1'b1, 6 + int'(rnd[7:5]));
    SRC.zero(8);
    SRC.glitch();
    cyc(12);
    rd(8'h18, n, 32'hFFFF);
    rd(8'h1C, n << 9, 32'hFFFF);
    apb(1'b1, 8'h08, 32'h1234);
    apb(1'b1, 8'h00, 32'h50);
    rd(8'h1C, 32'h1234 - (n << 9), 32'hFFFF);
    apb(1'b1, 8'h00, 32'h80);
    SRC.quad(3, 1'b0, 7);
    cyc(12);
    rd(8'h18, 32'hFFFD, 32'hFFFF);
    SRC.zero(8);
    cyc(12);
    rd(8'h18, 32'h7F, 32'hFFFF);
    SRC.quad(2, 1'b1, 7);
    SRC.zero(8);
    cyc(12);
    rd(8'h18, 32'h0, 32'hFFFF);
    apb(1'b1, 8'h00, 32'hA0);
    SRC.step(5, 1'b1, 6);
    SRC.step(2, 1'b0, 6);
    cyc(12);
    rd(8'h18, 32'h3, 32'hFFFF);
    rd(8'h1C, 32'h2A34, 32'hFFFF);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h00, {24'h0, tbl[i][19:12]});
      rd(8'h00, {24'h0, tbl[i][11:4]}, 32'h3F);
      rd(8'h18, {13'h0, tbl[i][3:1], 16'h0}, 32'h70000);
      chk({31'h0, pos_ctrl_en}, {31'h0, tbl[i][0]});
    end
    apb(1'b1, 8'h0C, 32'h2);
    apb(1'b1, 8'h10, 32'h3);
    rnd = lfsr(rnd);
    profile_pos <= rnd;
    apb(1'b1, 8'h00, 32'hA6);
    cyc(SCYC + 10);
    SRC.step(4, 1'b1, 6);
    cyc(3 * SCYC + 40);
    rd(8'h20, 32'd5461, 32'hFFFFFFFF);
    chk(pos_setpoint, rnd + 32'd5461);
    apb(1'b1, 8'h00, 32'h2D);
    SRC.step(2, 1'b1, 6);
    cyc(2 * SCYC + 40);
    chk({31'h0, speed_offset != 16'h0}, 32'h1);
    chk({16'h0, pos_feedfwd}, 32'h0);
    chk(pos_setpoint, rnd);
    apb(1'b1, 8'h00, 32'h26);
    cyc(4);
    chk({31'h0, pos_feedfwd != 16'h0}, 32'h1);
    chk({16'h0, speed_offset}, 32'h0);
    apb(1'b1, 8'h14, 32'h7);
    rd(8'h14, 32'h7, 32'hF);
    close_out();
  end
endmodule
